// File: rtl/csc_defs.svh
// register offsets, field positions, reset values and timing counts for the strap config block
`ifndef CSC_DEFS_SVH
`define CSC_DEFS_SVH
`define CSC_ADDR_DELAY 8'hD1
`define CSC_ADDR_STRAP 8'hD2
`define CSC_ADDR_LOOP 8'hD3
`define CSC_PGDLY_MSB 5
`define CSC_PGDLY_LSB 3
`define CSC_PODLY_MSB 2
`define CSC_PODLY_LSB 0
`define CSC_TRACK_BIT 7
`define CSC_EXTRAMP_BIT 6
`define CSC_FSK_BIT 4
`define CSC_SSTIME_MSB 3
`define CSC_SSTIME_LSB 2
`define CSC_UV_BIT 1
`define CSC_MODE_BIT 0
`define CSC_RAMP_BIT 7
`define CSC_RRES_MSB 5
`define CSC_RRES_LSB 4
`define CSC_FREQ_MSB 2
`define CSC_FREQ_LSB 0
`define CSC_PGDLY_RST 3'h2
`define CSC_PODLY_RST 3'h2
`define CSC_FSK_RST 1'b1
`define CSC_FREQ_RST 3'h3
`define CSC_DELAY_BASE_NS 256000
`define CSC_CLK_PERIOD_NS 4
`define CSC_PGDLY_TOP_SHIFT 5'h9
`define CSC_STRAP_SYNC_CYC 2'h2
`endif

// File: rtl/csc_pkg.sv
// types shared by the strap config block
package csc_pkg;
  typedef struct packed {
    logic ref_track;
    logic ext_ramp;
    logic [1:0] ss_time;
    logic uv;
    logic cond_mode;
    logic ramp;
    logic [1:0] ramp_res;
  } csc_strap_t;

  typedef struct packed {
    logic [2:0] powergood_delay_sel;
    logic [2:0] poweron_delay_sel;
    logic reference_tracking_sel;
    logic external_ramp_sel;
    logic softstart_skip_force;
    logic [1:0] softstart_time_sel;
    logic undervoltage_response_sel;
    logic conduction_mode_sel;
    logic ramp_injection_enable;
    logic [1:0] ramp_resistor_sel;
    logic [2:0] switching_freq_sel;
  } csc_cfg_t;
endpackage : csc_pkg

// File: rtl/csc_delay_timer.sv
// delay counter: done rises target cycles after run goes high, drops with run
module csc_delay_timer import csc_pkg::*; #(
  parameter int W = 26
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic run_i,
  input wire logic [W-1:0] target_i,
  output logic done_o
);
  logic [W-1:0] cnt_q;
  logic done_q;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || !run_i) begin
      cnt_q <= '0;
    end else if (!done_q) begin
      cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1}; // [RQ15]
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || !run_i) begin
      done_q <= 1'b0;
    end else if (cnt_q == target_i - {{(W-1){1'b0}}, 1'b1}) begin
      done_q <= 1'b1; // [RQ15]
    end
  end

  assign done_o = done_q;

  property p_done_at_target;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      $rose(done_q) |-> $past(cnt_q) == $past(target_i) - {{(W-1){1'b0}}, 1'b1};
  endproperty
  a_done_at_target: assert property (p_done_at_target) else $error("delay done at wrong count"); // [RQ15]
endmodule : csc_delay_timer

// File: rtl/csc_regs.sv
// converter configuration registers (strap and loop bytes partly strap-loaded, delay byte reset-only) with power-on and power-good delay timers
// Operation
// [RQ1] power-good delay doubles from 256us, top 131ms
// [RQ2] power-on delay doubles from 256us to 32.768ms
// [RQ3] delay byte: power-good 5:3, power-on 2:0, reset 010
// [RQ4] host overrides last until next power-on reset
// [RQ5] bit7 selects internal reference or external tracking
// [RQ6] bit6 selects internal ramp or external sequencing
// [RQ7] bit4 forces skip during soft start, resets 1
// [RQ8] bits3:2 pick soft-start 1, 2, 4, 8 ms
// [RQ9] bit1 picks hiccup or latch-off on undervoltage
// [RQ10] bit0 picks pulse-skip or forced continuous mode
// [RQ11] loop bit7 enables internal ramp injection
// [RQ12] loop bits5:4 scale ramp resistor
// [RQ13] loop bits2:0 pick switching frequency, reset 011
// [RQ14] unused bits read zero, ignore writes
// [RQ15] delays are counters on the internal clock
`include "csc_defs.svh"
module csc_regs import csc_pkg::*; #(
  parameter int BASE_CYC = `CSC_DELAY_BASE_NS / `CSC_CLK_PERIOD_NS,
  parameter int TW = 26
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic wr_en_i,
  input wire logic [7:0] wr_data_i,
  input wire logic rd_en_i,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  input wire csc_strap_t strap_i,
  input wire logic enable_i,
  input wire logic regulation_ok_i,
  input wire logic softstart_active_i,
  output csc_cfg_t cfg_o,
  output logic pulse_skip_o,
  output logic softstart_start_o,
  output logic power_good_output_o
);
  localparam int SW = $bits(csc_strap_t) + 3;

  // pins from the analog side and strap straps: two flops before use
  logic [SW-1:0] meta_q;
  logic [SW-1:0] sync_q;
  csc_strap_t strap_s;
  logic en_s;
  logic reg_ok_s;
  logic ss_act_s;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= {strap_i, enable_i, regulation_ok_i, softstart_active_i};
      sync_q <= meta_q;
    end
  end
  assign {strap_s, en_s, reg_ok_s, ss_act_s} = sync_q;

  // strap capture after reset release, once the synchroniser holds real pin values
  logic [1:0] ld_cnt_q;
  logic strap_ld;
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ld_cnt_q <= 2'h0;
    end else if (ld_cnt_q != 2'h3) begin
      ld_cnt_q <= ld_cnt_q + 2'h1;
    end
  end
  assign strap_ld = (ld_cnt_q == `CSC_STRAP_SYNC_CYC);

  logic wr_dly;
  logic wr_strap;
  logic wr_loop;
  // a strap load outranks a host write landing in the same cycle
  assign wr_dly = wr_en_i && (cmd_code_i == `CSC_ADDR_DELAY);
  assign wr_strap = wr_en_i && (cmd_code_i == `CSC_ADDR_STRAP) && !strap_ld;
  assign wr_loop = wr_en_i && (cmd_code_i == `CSC_ADDR_LOOP) && !strap_ld;

  csc_cfg_t cfg_q;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      cfg_q.powergood_delay_sel <= `CSC_PGDLY_RST; // [RQ3]
      cfg_q.poweron_delay_sel <= `CSC_PODLY_RST; // [RQ3]
    end else if (wr_dly) begin
      cfg_q.powergood_delay_sel <= wr_data_i[`CSC_PGDLY_MSB:`CSC_PGDLY_LSB]; // [RQ3]
      cfg_q.poweron_delay_sel <= wr_data_i[`CSC_PODLY_MSB:`CSC_PODLY_LSB]; // [RQ3]
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      cfg_q.reference_tracking_sel <= 1'b0;
      cfg_q.external_ramp_sel <= 1'b0;
      cfg_q.softstart_time_sel <= 2'h0;
      cfg_q.undervoltage_response_sel <= 1'b0;
      cfg_q.conduction_mode_sel <= 1'b0;
    end else if (strap_ld) begin
      cfg_q.reference_tracking_sel <= strap_s.ref_track; // [RQ4] [RQ5]
      cfg_q.external_ramp_sel <= strap_s.ext_ramp; // [RQ6]
      cfg_q.softstart_time_sel <= strap_s.ss_time; // [RQ8]
      cfg_q.undervoltage_response_sel <= strap_s.uv; // [RQ9]
      cfg_q.conduction_mode_sel <= strap_s.cond_mode; // [RQ10]
    end else if (wr_strap) begin
      cfg_q.reference_tracking_sel <= wr_data_i[`CSC_TRACK_BIT]; // [RQ5]
      cfg_q.external_ramp_sel <= wr_data_i[`CSC_EXTRAMP_BIT]; // [RQ6]
      cfg_q.softstart_time_sel <= wr_data_i[`CSC_SSTIME_MSB:`CSC_SSTIME_LSB]; // [RQ8]
      cfg_q.undervoltage_response_sel <= wr_data_i[`CSC_UV_BIT]; // [RQ9]
      cfg_q.conduction_mode_sel <= wr_data_i[`CSC_MODE_BIT]; // [RQ10]
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      cfg_q.softstart_skip_force <= `CSC_FSK_RST; // [RQ7]
    end else if (wr_strap) begin
      cfg_q.softstart_skip_force <= wr_data_i[`CSC_FSK_BIT]; // [RQ7]
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      cfg_q.ramp_injection_enable <= 1'b0;
      cfg_q.ramp_resistor_sel <= 2'h0;
    end else if (strap_ld) begin
      cfg_q.ramp_injection_enable <= strap_s.ramp; // [RQ4] [RQ11]
      cfg_q.ramp_resistor_sel <= strap_s.ramp_res; // [RQ12]
    end else if (wr_loop) begin
      cfg_q.ramp_injection_enable <= wr_data_i[`CSC_RAMP_BIT]; // [RQ11]
      cfg_q.ramp_resistor_sel <= wr_data_i[`CSC_RRES_MSB:`CSC_RRES_LSB]; // [RQ12]
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      cfg_q.switching_freq_sel <= `CSC_FREQ_RST; // [RQ13]
    end else if (wr_loop) begin
      cfg_q.switching_freq_sel <= wr_data_i[`CSC_FREQ_MSB:`CSC_FREQ_LSB]; // [RQ13]
    end
  end

  assign cfg_o = cfg_q;

  // readback; unused bits are never stored so they read zero
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    unique case (cmd_code_i)
      `CSC_ADDR_DELAY: begin
        rd_mux[`CSC_PGDLY_MSB:`CSC_PGDLY_LSB] = cfg_q.powergood_delay_sel;
        rd_mux[`CSC_PODLY_MSB:`CSC_PODLY_LSB] = cfg_q.poweron_delay_sel;
      end
      `CSC_ADDR_STRAP: begin
        rd_mux[`CSC_TRACK_BIT] = cfg_q.reference_tracking_sel;
        rd_mux[`CSC_EXTRAMP_BIT] = cfg_q.external_ramp_sel;
        rd_mux[`CSC_FSK_BIT] = cfg_q.softstart_skip_force;
        rd_mux[`CSC_SSTIME_MSB:`CSC_SSTIME_LSB] = cfg_q.softstart_time_sel;
        rd_mux[`CSC_UV_BIT] = cfg_q.undervoltage_response_sel;
        rd_mux[`CSC_MODE_BIT] = cfg_q.conduction_mode_sel;
      end
      `CSC_ADDR_LOOP: begin
        rd_mux[`CSC_RAMP_BIT] = cfg_q.ramp_injection_enable;
        rd_mux[`CSC_RRES_MSB:`CSC_RRES_LSB] = cfg_q.ramp_resistor_sel;
        rd_mux[`CSC_FREQ_MSB:`CSC_FREQ_LSB] = cfg_q.switching_freq_sel;
      end
      default: rd_mux = 8'h00; // [RQ14]
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rd_data_o <= 8'h00;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= rd_en_i;
      if (rd_en_i) begin
        rd_data_o <= rd_mux;
      end
    end
  end

  // skip is forced only while soft start runs; mode bit rules otherwise
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      pulse_skip_o <= 1'b1;
    end else begin
      pulse_skip_o <= (cfg_q.softstart_skip_force && ss_act_s) || !cfg_q.conduction_mode_sel; // [RQ7] [RQ10]
    end
  end

  // delay targets: base step shifted by the code; power-good top code jumps to 512 steps
  logic [TW-1:0] pg_target;
  logic [TW-1:0] po_target;
  logic [4:0] pg_shift;
  assign pg_shift = (cfg_q.powergood_delay_sel == 3'h7) ? `CSC_PGDLY_TOP_SHIFT : {2'h0, cfg_q.powergood_delay_sel};
  assign pg_target = TW'(BASE_CYC) << pg_shift; // [RQ1]
  assign po_target = TW'(BASE_CYC) << cfg_q.poweron_delay_sel; // [RQ2]

  logic po_done;
  logic po_done_q;
  logic pg_done;

  csc_delay_timer #(.W(TW)) u_poweron (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .run_i(en_s),
    .target_i(po_target),
    .done_o(po_done)
  );

  csc_delay_timer #(.W(TW)) u_powergood (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .run_i(reg_ok_s),
    .target_i(pg_target),
    .done_o(pg_done)
  );

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      po_done_q <= 1'b0;
      softstart_start_o <= 1'b0;
    end else begin
      po_done_q <= po_done;
      softstart_start_o <= po_done && !po_done_q; // [RQ15]
    end
  end
  assign power_good_output_o = pg_done; // [RQ15]

  property p_pg_top;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      cfg_q.powergood_delay_sel == 3'h7 |-> pg_target == TW'(BASE_CYC) * 512;
  endproperty
  a_pg_top: assert property (p_pg_top) else $error("power-good top delay wrong"); // [RQ1]
  property p_po_code;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      cfg_q.poweron_delay_sel == 3'h7 |-> po_target == TW'(BASE_CYC) * 128;
  endproperty
  a_po_code: assert property (p_po_code) else $error("poweron top delay wrong"); // [RQ2]
  property p_dly_reset;
    @(posedge ref_clk_i) $fell(sys_rst_i) |-> cfg_q.powergood_delay_sel == 3'h2 && cfg_q.poweron_delay_sel == 3'h2;
  endproperty
  a_dly_reset: assert property (p_dly_reset) else $error("delay reset value wrong"); // [RQ3]
  property p_strap_load;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      strap_ld |=> cfg_q.reference_tracking_sel == $past(strap_s.ref_track)
        && cfg_q.ramp_resistor_sel == $past(strap_s.ramp_res);
  endproperty
  a_strap_load: assert property (p_strap_load) else $error("strap not reloaded"); // [RQ4]
  property p_wr_strap;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      wr_strap |=> cfg_q.reference_tracking_sel == $past(wr_data_i[7]) && cfg_q.external_ramp_sel == $past(wr_data_i[6])
        && cfg_q.softstart_time_sel == $past(wr_data_i[3:2]) && cfg_q.undervoltage_response_sel == $past(wr_data_i[1]);
  endproperty
  a_wr_strap: assert property (p_wr_strap) else $error("strap register write lost"); // [RQ5]
  property p_skip;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      cfg_q.softstart_skip_force && ss_act_s |=> pulse_skip_o;
  endproperty
  a_skip: assert property (p_skip) else $error("skip not forced in soft start"); // [RQ7]
  property p_mode;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      !ss_act_s && cfg_q.conduction_mode_sel |=> !pulse_skip_o;
  endproperty
  a_mode: assert property (p_mode) else $error("forced continuous not honoured"); // [RQ10]
  property p_wr_loop;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      wr_loop |=> cfg_q.ramp_injection_enable == $past(wr_data_i[7]) && cfg_q.switching_freq_sel == $past(wr_data_i[2:0]);
  endproperty
  a_wr_loop: assert property (p_wr_loop) else $error("loop register write lost"); // [RQ11]
  property p_freq_reset;
    @(posedge ref_clk_i) $fell(sys_rst_i) |-> cfg_q.switching_freq_sel == 3'h3 && cfg_q.softstart_skip_force;
  endproperty
  a_freq_reset: assert property (p_freq_reset) else $error("loop reset value wrong"); // [RQ13]
  property p_rsv_zero;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      rd_en_i && cmd_code_i == `CSC_ADDR_LOOP |=> rd_valid_o && rd_data_o[6] == 1'b0 && rd_data_o[3] == 1'b0;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("unused bit reads one"); // [RQ14]
  c_strap_wr: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i) wr_strap);
  c_power_good_output: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i) $rose(power_good_output_o));
  c_ss_start: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i) softstart_start_o);
endmodule : csc_regs

// File: verification/csc_host_model.sv
// host-side register bus model that issues single-byte writes and reads
module csc_host_model (
  input wire logic clk_i,
  output logic [7:0] cmd_code_o,
  output logic wr_en_o,
  output logic [7:0] wr_data_o,
  output logic rd_en_o,
  input wire logic [7:0] rd_data_i,
  input wire logic rd_valid_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmd_code_o = 8'h00;
    wr_en_o = 1'b0;
    wr_data_o = 8'h00;
    rd_en_o = 1'b0;
  end
  // idle bus shows inverted values so a stale code or byte is never mistaken for a live one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cmd_code_o <= a;
    wr_data_o <= d;
    wr_en_o <= 1'b1;
    @(posedge clk_i);
    wr_en_o <= 1'b0;
    cmd_code_o <= ~a;
    wr_data_o <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge clk_i);
    cmd_code_o <= a;
    rd_en_o <= 1'b1;
    @(posedge clk_i);
    rd_en_o <= 1'b0;
    cmd_code_o <= ~a;
    #1;
    ok = rd_valid_i;
    d = rd_data_i;
  endtask : rd
endmodule : csc_host_model

// File: verification/csc_regs_tb.sv
// self-checking bench for the strap config registers and delay timers
module csc_regs_tb import csc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BASE = 4;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] cmd, wdat, rdat;
  logic wen, ren, rval, pskip, ss_go, pg_out;
  logic en = 1'b0, rok = 1'b0, ss_act = 1'b0;
  csc_strap_t strap = csc_strap_t'(9'h156);
  csc_cfg_t cfg;
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0;
  always #2 ref_clk = ~ref_clk;
  csc_regs #(.BASE_CYC(BASE), .TW(26)) dut (.ref_clk_i(ref_clk), .sys_rst_i(sys_rst),
    .cmd_code_i(cmd), .wr_en_i(wen), .wr_data_i(wdat), .rd_en_i(ren), .rd_data_o(rdat),
    .rd_valid_o(rval), .strap_i(strap), .enable_i(en), .regulation_ok_i(rok),
    .softstart_active_i(ss_act), .cfg_o(cfg), .pulse_skip_o(pskip),
    .softstart_start_o(ss_go), .power_good_output_o(pg_out));
  csc_host_model host (.clk_i(ref_clk), .cmd_code_o(cmd), .wr_en_o(wen), .wr_data_o(wdat),
    .rd_en_o(ren), .rd_data_i(rdat), .rd_valid_i(rval));
  task automatic wrap_up;
    $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  // cut a hang short well past the few thousand cycles the delay sweep needs
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up;
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic ok;
    host.rd(a, d, ok);
    chk(ok, 1'b1);
    chk(d, e);
  endtask : rd
  task automatic settle;
    repeat (6) @(posedge ref_clk);
    #1;
  endtask : settle
  // strap pins are held steady across the load window after release
  task automatic do_reset;
    sys_rst <= 1'b1;
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (5) @(posedge ref_clk);
  endtask : do_reset
  task automatic t_reset;
    rd(8'hD1, 8'h12);
    rd(8'hD2, 8'h9A);
    rd(8'hD3, 8'hA3);
    rd(8'hD0, 8'h00);
    chk(pskip, 1'b1);
    $display("test reset done");
  endtask : t_reset
  task automatic t_write;
    host.wr(8'hD2, 8'hFF);
    rd(8'hD2, 8'hDF);
    host.wr(8'hD3, 8'hFF);
    rd(8'hD3, 8'hB7);
    host.wr(8'hD1, 8'hFF);
    rd(8'hD1, 8'h3F);
    chk(cfg.reference_tracking_sel, 1'b1);
    for (int i = 0; i < 8; i++) begin
      host.wr(8'hD3, {2'b00, i[1:0], 1'b0, i[2:0]});
      host.wr(8'hD2, {4'h0, i[1:0], 2'b00});
      #1;
      chk(cfg.switching_freq_sel, i[2:0]);
      chk(cfg.ramp_resistor_sel, i[1:0]);
      chk(cfg.softstart_time_sel, i[1:0]);
    end
    $display("test write done");
  endtask : t_write
  task automatic t_por;
    @(posedge ref_clk);
    strap <= csc_strap_t'(9'h0A9);
    do_reset;
    rd(8'hD2, 8'h55);
    rd(8'hD3, 8'h13);
    rd(8'hD1, 8'h12);
    $display("test power-on reload done");
  endtask : t_por
  task automatic t_skip;
    settle;
    chk(pskip, 1'b0);
    @(posedge ref_clk);
    ss_act <= 1'b1;
    settle;
    chk(pskip, 1'b1);
    host.wr(8'hD2, 8'h45);
    settle;
    chk(pskip, 1'b0);
    host.wr(8'hD2, 8'h44);
    settle;
    chk(pskip, 1'b1);
    @(posedge ref_clk);
    ss_act <= 1'b0;
    $display("test skip done");
  endtask : t_skip
  task automatic meas(input logic pg, input logic [2:0] k, output int n);
    host.wr(8'hD1, pg ? {2'b00, k, 3'h2} : {2'b00, 3'h2, k});
    @(posedge ref_clk);
    en <= pg;
    rok <= 1'b0;
    settle;
    @(posedge ref_clk);
    en <= 1'b1;
    rok <= pg;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while ((pg ? pg_out : ss_go) !== 1'b1 && n < 3000);
  endtask : meas
  // fixed sync latency cancels out, so codes 1 to 7 are judged by their distance from code 0; code 0 is checked against a BASE to BASE + 8 window
  task automatic t_delay;
    int n0, n;
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 8; k++) begin
        meas(p[0], k[2:0], n);
        if (k == 0) n0 = n;
        if (k == 0) chk(n0 >= BASE && n0 <= BASE + 8, 1'b1);
        else chk(n - n0, (p == 1 && k == 7) ? BASE * 511 : BASE * ((1 << k) - 1));
      end
    end
    $display("test delay done");
  endtask : t_delay
  initial begin
    do_reset;
    t_reset;
    t_write;
    t_por;
    t_skip;
    t_delay;
    wrap_up;
  end
endmodule : csc_regs_tb
